//--- rtl/vmac_pkg.sv
// constants, encodings and register map of the voltage monitor converter control
// assumes a 40 MHz system clock and the documented two-wire management bus
package vmac_pkg;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 700000;
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int ADC_BITS = 10;
  localparam int AVG_SAMPLES = 16;
  localparam int AVG_SHIFT = 4;
  localparam int ACC_BITS = ADC_BITS + AVG_SHIFT;
  localparam logic [9:0] NOMINAL_CODE = 10'h300;
  localparam logic [6:0] SMB_DEV_ADDR = 7'h2E;

  localparam logic [7:0] REG_CS_READING = 8'h21;
  localparam logic [7:0] REG_DS_READING = 8'h22;
  localparam logic [7:0] REG_CONFIG_ONE = 8'h40;
  localparam logic [7:0] REG_STATUS = 8'h41;
  localparam logic [7:0] REG_CS_LOW = 8'h46;
  localparam logic [7:0] REG_CS_HIGH = 8'h47;
  localparam logic [7:0] REG_DS_LOW = 8'h48;
  localparam logic [7:0] REG_DS_HIGH = 8'h49;
  localparam logic [7:0] REG_FAN1_CHSEL = 8'h55;
  localparam logic [7:0] REG_CONFIG_TWO = 8'h73;

  localparam logic [7:0] READING_RST = 8'h00;
  localparam logic [7:0] LIMIT_LO_RST = 8'h00;
  localparam logic [7:0] LIMIT_HI_RST = 8'hFF;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [1:0] STATUS_RST = 2'h0;

  localparam int CFG1_VDD_5V_BIT = 7;
  localparam int CFG2_AVG_OFF_BIT = 4;
  localparam int CFG2_BYPASS_BIT = 5;
  localparam int CFG2_SINGLE_BIT = 6;
  localparam int CHSEL_MSB = 7;
  localparam int CHSEL_LSB = 5;
  localparam int STAT_CS_BIT = 0;
  localparam int STAT_DS_BIT = 1;

  localparam logic [2:0] CH_CHIPSET = 3'h1;
  localparam logic [2:0] CH_DEVICE = 3'h2;
  localparam logic [2:0] CH_REMOTE1 = 3'h5;
  localparam logic [2:0] CH_LOCAL = 3'h6;
  localparam logic [2:0] CH_REMOTE2 = 3'h7;

  typedef enum logic [2:0] {
    SMB_IDLE, SMB_ADDR, SMB_ADDR_ACK, SMB_WR, SMB_WR_ACK, SMB_RD, SMB_RD_ACK
  } vmac_smb_e;
endpackage : vmac_pkg

//--- rtl/vmac_conv_if.sv
// carrier between the sequencer and the successive-approximation engine
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface vmac_conv_if;
  logic start;
  logic cmp;
  logic busy;
  logic done;
  logic [9:0] result;
  logic [9:0] dac_code;
  modport ctl (output start, output cmp, input busy, input done, input result, input dac_code);
  modport sar (input start, input cmp, output busy, output done, output result, output dac_code);
endinterface : vmac_conv_if

//--- rtl/vmac_sar.sv
// successive-approximation engine: ten trials spread over one conversion time
// assumes the comparator level arrives already synchronised
`timescale 1ns/1ps
module vmac_sar #(
  parameter int CONV_CYCLES = vmac_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  vmac_conv_if.sar cv
);
  import vmac_pkg::*;
  localparam int STEP_RAW = CONV_CYCLES / ADC_BITS;
  localparam int STEP_CYCLES = (STEP_RAW < 1) ? 1 : STEP_RAW;
  localparam logic [15:0] STEP_LAST = 16'(STEP_CYCLES - 1);

  logic [15:0] step_q;
  logic [3:0] bit_q;
  logic [9:0] kept;

  // drop the trial bit when the input sits below the trial level
  always_comb begin
    kept = cv.dac_code;
    if (!cv.cmp) begin
      kept[bit_q] = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    cv.done <= 1'b0;
    if (sys_rst) begin
      cv.busy <= 1'b0;
      cv.result <= 10'h000;
      cv.dac_code <= 10'h000;
      step_q <= 16'h0000;
      bit_q <= 4'h0;
    end else if (!cv.busy) begin
      if (cv.start) begin
        cv.busy <= 1'b1;
        cv.dac_code <= 10'h200;
        bit_q <= 4'h9;
        step_q <= 16'h0000;
      end
    end else if (step_q == STEP_LAST) begin
      step_q <= 16'h0000;
      if (bit_q == 4'h0) begin
        cv.result <= kept;
        cv.done <= 1'b1;
        cv.busy <= 1'b0;
        cv.dac_code <= kept;
      end else begin
        cv.dac_code <= kept | (10'h001 << (bit_q - 4'h1));
        bit_q <= bit_q - 4'h1;
      end
    end else begin
      step_q <= step_q + 16'h0001;
    end
  end

  // helper: cycles since start, only read by the checks
  logic [19:0] span_q;
  always_ff @(posedge clk) begin
    if (sys_rst || cv.start) begin
      span_q <= 20'h00000;
    end else if (cv.busy) begin
      span_q <= span_q + 20'h00001;
    end
  end

  a_conv_length: assert property (@(posedge clk) disable iff (sys_rst)
    cv.done |-> span_q == 20'(ADC_BITS * STEP_CYCLES))
    else $error("conversion did not take one full conversion time");
  a_sar_busy_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (cv.start && !cv.busy) |=> cv.busy[*8])
    else $error("converter dropped busy right after start");
  c_conv_done: cover property (@(posedge clk) disable iff (sys_rst) cv.done);
endmodule : vmac_sar

//--- rtl/vmac_top.sv
// voltage monitor converter control: bus slave, register file, sequencer, limits
// assumes an analog front end with mux, attenuator, trial dac and comparator
`timescale 1ns/1ps
module vmac_top #(
  parameter int CONV_CYCLES = vmac_pkg::CONV_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic smb_scl,
  input wire logic smb_sda_in,
  output logic smb_sda_out,
  output logic smb_sda_oe,
  output logic smb_alert_n,
  input wire logic adc_cmp,
  output logic [9:0] adc_dac_code,
  output logic [2:0] adc_mux_sel,
  output logic atten_bypass,
  output logic device_5v_scale
);
  import vmac_pkg::*;

  vmac_conv_if conv ();

  vmac_sar #(.CONV_CYCLES(CONV_CYCLES)) u_sar (
    .clk(clk),
    .sys_rst(sys_rst),
    .cv(conv.sar)
  );

  function automatic logic [2:0] next_chan(input logic [2:0] c);
    unique case (c)
      CH_CHIPSET: next_chan = CH_DEVICE;
      CH_DEVICE: next_chan = CH_REMOTE1;
      CH_REMOTE1: next_chan = CH_LOCAL;
      CH_LOCAL: next_chan = CH_REMOTE2;
      default: next_chan = CH_CHIPSET;
    endcase
  endfunction : next_chan

  function automatic logic beyond(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    beyond = (v > hi) || (v < lo);
  endfunction : beyond

  // registers
  logic [7:0] cs_reading_q;
  logic [7:0] ds_reading_q;
  logic [7:0] config_one_q;
  logic [7:0] config_two_q;
  logic [7:0] cs_low_q;
  logic [7:0] cs_high_q;
  logic [7:0] ds_low_q;
  logic [7:0] ds_high_q;
  logic [7:0] fan1_chsel_q;
  logic [1:0] status_q;
  logic [1:0] status_set;
  logic status_clr;

  // pin synchronisers; stage one feeds stage two only
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  logic cmp_s1_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      cmp_s1_q <= 1'b0;
      conv.cmp <= 1'b0;
    end else begin
      scl_s1_q <= smb_scl;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= smb_sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      cmp_s1_q <= adc_cmp;
      conv.cmp <= cmp_s1_q;
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign bus_start = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign bus_stop = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;

  // bus slave
  vmac_smb_e smb_q;
  logic [7:0] shift_q;
  logic [3:0] cnt_q;
  logic rw_q;
  logic first_q;
  logic nack_q;
  logic [7:0] ptr_q;
  logic [7:0] rd_data;
  logic wr_fire;

  always_comb begin
    unique case (ptr_q)
      REG_CS_READING: rd_data = cs_reading_q;
      REG_DS_READING: rd_data = ds_reading_q;
      REG_CONFIG_ONE: rd_data = config_one_q;
      REG_STATUS: rd_data = {6'h00, status_q};
      REG_CS_LOW: rd_data = cs_low_q;
      REG_CS_HIGH: rd_data = cs_high_q;
      REG_DS_LOW: rd_data = ds_low_q;
      REG_DS_HIGH: rd_data = ds_high_q;
      REG_FAN1_CHSEL: rd_data = fan1_chsel_q;
      REG_CONFIG_TWO: rd_data = config_two_q;
      default: rd_data = 8'h00;
    endcase
  end

  logic load_rd;
  assign load_rd = scl_fall && ((smb_q == SMB_ADDR_ACK && rw_q) ||
                                (smb_q == SMB_RD_ACK && !nack_q));
  assign status_clr = load_rd && (ptr_q == REG_STATUS);
  assign wr_fire = scl_fall && smb_q == SMB_WR && cnt_q == 4'h8 && !first_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smb_q <= SMB_IDLE;
      shift_q <= 8'h00;
      cnt_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      ptr_q <= 8'h00;
    end else if (bus_stop) begin
      smb_q <= SMB_IDLE;
    end else if (bus_start) begin
      smb_q <= SMB_ADDR;
      cnt_q <= 4'h0;
    end else if (scl_rise) begin
      if (smb_q == SMB_ADDR || smb_q == SMB_WR) begin
        shift_q <= {shift_q[6:0], sda_s2_q};
        cnt_q <= cnt_q + 4'h1;
      end
      if (smb_q == SMB_RD_ACK) begin
        nack_q <= sda_s2_q;
      end
    end else if (scl_fall) begin
      unique case (smb_q)
        SMB_ADDR: begin
          if (cnt_q == 4'h8) begin
            // foreign address: stay off the bus until the next start
            smb_q <= (shift_q[7:1] == SMB_DEV_ADDR) ? SMB_ADDR_ACK : SMB_IDLE;
            rw_q <= shift_q[0];
          end
        end
        SMB_ADDR_ACK: begin
          cnt_q <= 4'h0;
          first_q <= 1'b1;
          if (rw_q) begin
            smb_q <= SMB_RD;
            shift_q <= rd_data;
          end else begin
            smb_q <= SMB_WR;
          end
        end
        SMB_WR: begin
          if (cnt_q == 4'h8) begin
            smb_q <= SMB_WR_ACK;
            if (first_q) begin
              ptr_q <= shift_q;
            end
          end
        end
        SMB_WR_ACK: begin
          smb_q <= SMB_WR;
          cnt_q <= 4'h0;
          first_q <= 1'b0;
        end
        SMB_RD: begin
          if (cnt_q == 4'h7) begin
            smb_q <= SMB_RD_ACK;
          end else begin
            shift_q <= {shift_q[6:0], 1'b1};
            cnt_q <= cnt_q + 4'h1;
          end
        end
        SMB_RD_ACK: begin
          cnt_q <= 4'h0;
          // master ack rereads the same register; no pointer auto-increment
          if (nack_q) begin
            smb_q <= SMB_IDLE;
          end else begin
            smb_q <= SMB_RD;
            shift_q <= rd_data;
          end
        end
        SMB_IDLE: begin
        end
      endcase
    end
  end

  // open drain: only ever pull low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smb_sda_out <= 1'b0;
      smb_sda_oe <= 1'b0;
    end else begin
      smb_sda_out <= 1'b0;
      smb_sda_oe <= (smb_q == SMB_ADDR_ACK) || (smb_q == SMB_WR_ACK) ||
                    (smb_q == SMB_RD && !shift_q[7]);
    end
  end

  // writable registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      config_one_q <= CONFIG_RST;
      config_two_q <= CONFIG_RST;
      fan1_chsel_q <= CONFIG_RST;
      cs_low_q <= LIMIT_LO_RST;
      cs_high_q <= LIMIT_HI_RST;
      ds_low_q <= LIMIT_LO_RST;
      ds_high_q <= LIMIT_HI_RST;
    end else if (wr_fire) begin
      unique case (ptr_q)
        REG_CONFIG_ONE: config_one_q <= shift_q;
        REG_CONFIG_TWO: config_two_q <= shift_q;
        REG_FAN1_CHSEL: fan1_chsel_q <= shift_q;
        REG_CS_LOW: cs_low_q <= shift_q;
        REG_CS_HIGH: cs_high_q <= shift_q;
        REG_DS_LOW: ds_low_q <= shift_q;
        REG_DS_HIGH: ds_high_q <= shift_q;
        default: begin
        end
      endcase
    end
  end

  // analog front end controls
  logic avg_off, single_mode;
  logic [2:0] single_sel;
  assign avg_off = config_two_q[CFG2_AVG_OFF_BIT];
  assign single_mode = config_two_q[CFG2_SINGLE_BIT];
  assign single_sel = fan1_chsel_q[CHSEL_MSB:CHSEL_LSB];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      atten_bypass <= 1'b0;
      device_5v_scale <= 1'b0;
    end else begin
      // attenuated path puts nominal supply at three-quarter scale
      atten_bypass <= config_two_q[CFG2_BYPASS_BIT];
      device_5v_scale <= config_one_q[CFG1_VDD_5V_BIT];
    end
  end

  // sequencer and averaging
  logic [ACC_BITS-1:0] acc_q;
  logic [ACC_BITS-1:0] sum;
  logic [3:0] samp_q;
  logic meas_end;
  logic [9:0] avg;
  logic [9:0] meas_q;
  logic meas_valid_q;
  logic [2:0] meas_chan_q;

  assign sum = acc_q + {4'h0, conv.result};
  assign avg = avg_off ? conv.result : sum[ACC_BITS-1:AVG_SHIFT];
  assign meas_end = conv.done && (avg_off || samp_q == 4'(AVG_SAMPLES - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      conv.start <= 1'b0;
    end else begin
      conv.start <= !conv.busy && !conv.start;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= '0;
      samp_q <= 4'h0;
      adc_mux_sel <= CH_CHIPSET;
    end else if (conv.done) begin
      if (meas_end) begin
        acc_q <= '0;
        samp_q <= 4'h0;
        // illegal select codes fall back to the chipset supply
        if (single_mode) begin
          adc_mux_sel <= (single_sel inside {CH_CHIPSET, CH_DEVICE, CH_REMOTE1, CH_LOCAL,
                                             CH_REMOTE2}) ? single_sel : CH_CHIPSET;
        end else begin
          adc_mux_sel <= next_chan(adc_mux_sel);
        end
      end else begin
        acc_q <= sum;
        samp_q <= samp_q + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meas_q <= 10'h000;
      meas_valid_q <= 1'b0;
      meas_chan_q <= CH_CHIPSET;
    end else begin
      meas_valid_q <= meas_end;
      if (meas_end) begin
        meas_q <= avg;
        meas_chan_q <= adc_mux_sel;
      end
    end
  end

  // temperature codes are converted but kept nowhere here
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cs_reading_q <= READING_RST;
      ds_reading_q <= READING_RST;
    end else if (meas_valid_q) begin
      if (meas_chan_q == CH_CHIPSET) begin
        cs_reading_q <= meas_q[9:2];
      end
      if (meas_chan_q == CH_DEVICE) begin
        ds_reading_q <= meas_q[9:2];
      end
    end
  end

  always_comb begin
    status_set = 2'h0;
    if (meas_valid_q && meas_chan_q == CH_CHIPSET) begin
      status_set[STAT_CS_BIT] = beyond(meas_q[9:2], cs_low_q, cs_high_q);
    end
    if (meas_valid_q && meas_chan_q == CH_DEVICE) begin
      status_set[STAT_DS_BIT] = beyond(meas_q[9:2], ds_low_q, ds_high_q);
    end
  end

  // a read clears, but a violation in the same cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= (status_q & ~{2{status_clr}}) | status_set;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      smb_alert_n <= 1'b1;
    end else begin
      smb_alert_n <= !(|status_q);
    end
  end

  assign adc_dac_code = conv.dac_code;

  // checks
  a_limit_reset: assert property (@(posedge clk)
    sys_rst |=> (cs_low_q == 8'h00 && cs_high_q == 8'hFF && ds_low_q == 8'h00 &&
                 ds_high_q == 8'hFF))
    else $error("limit registers not at reset values");
  a_limit_sets_flag: assert property (@(posedge clk) disable iff (sys_rst)
    (meas_valid_q && meas_chan_q == CH_CHIPSET && beyond(meas_q[9:2], cs_low_q, cs_high_q))
    |=> status_q[STAT_CS_BIT])
    else $error("chipset supply violation did not set status");
  a_alert_follows: assert property (@(posedge clk) disable iff (sys_rst)
    (meas_valid_q && meas_chan_q == CH_DEVICE && beyond(meas_q[9:2], ds_low_q, ds_high_q))
    |=> ##1 !smb_alert_n)
    else $error("device supply violation did not raise alert");
  a_avg_sixteen: assert property (@(posedge clk) disable iff (sys_rst)
    (conv.done && !avg_off && samp_q != 4'hF) |=> !meas_valid_q)
    else $error("averaged result stored before sixteen conversions");
  a_avg_off_each: assert property (@(posedge clk) disable iff (sys_rst)
    (conv.done && avg_off) |=> meas_valid_q && meas_q == $past(conv.result))
    else $error("averaging off did not store the single conversion");
  a_store_reading: assert property (@(posedge clk) disable iff (sys_rst)
    (meas_valid_q && meas_chan_q == CH_CHIPSET) |=> cs_reading_q == $past(meas_q[9:2]))
    else $error("chipset reading not updated");
  a_single_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (meas_end && single_mode && single_sel == CH_DEVICE) |=> adc_mux_sel == CH_DEVICE)
    else $error("single mode did not select the chosen input");
  a_round_robin: assert property (@(posedge clk) disable iff (sys_rst)
    (meas_end && !single_mode && adc_mux_sel == CH_CHIPSET) |=> adc_mux_sel == CH_DEVICE)
    else $error("round robin order broken");
  a_bypass_pin: assert property (@(posedge clk) disable iff (sys_rst)
    config_two_q[CFG2_BYPASS_BIT] [*2] |-> atten_bypass)
    else $error("attenuator bypass not driven");
  a_scale_pin: assert property (@(posedge clk) disable iff (sys_rst)
    config_one_q[CFG1_VDD_5V_BIT] [*2] |-> device_5v_scale)
    else $error("5 V scaling not driven");

  c_status_read: cover property (@(posedge clk) disable iff (sys_rst) status_clr && |status_q);
  c_single_mode: cover property (@(posedge clk) disable iff (sys_rst) meas_end && single_mode);
  c_bus_write: cover property (@(posedge clk) disable iff (sys_rst) wr_fire);
endmodule : vmac_top

//--- tb/vmac_smb_host.sv
// management bus master model: drives clock and data, reads the wire back
// assumes an open-drain data line with pull-up; device enable pulls it low
`timescale 1ns/1ps
module vmac_smb_host (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  import vmac_pkg::*;
  logic drv;
  logic nak;
  // released wire floats high through the pull-up; enabled, the device level wins
  assign sda = drv & (sda_oe ? sda_out : 1'b1);
  initial begin
    scl = 1'b1;
    drv = 1'b1;
    nak = 1'b0;
  end
  // eleven cycles per phase keeps both clock levels above the eight-cycle floor
  task automatic step(input logic c, input logic d);
    @(posedge clk);
    scl <= c;
    drv <= d;
    repeat (10) @(posedge clk);
  endtask : step
  task automatic start;
    step(1'b0, drv);
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
  endtask : start
  task automatic stop;
    step(1'b0, drv);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : stop
  // data only moves while the clock is low, never on its falling step
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic b;
    for (int i = 8; i >= 0; i--) begin
      b = (i == 0) ? 1'b1 : d[i-1];
      step(1'b0, drv);
      step(1'b0, b);
      step(1'b1, b);
      if (i > 0) begin
        q[i-1] = sda;
      end else begin
        ack = sda;
      end
    end
  endtask : xfer
  task automatic write_reg(input logic [7:0] p, input logic [7:0] v);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    start();
    xfer({SMB_DEV_ADDR, 1'b0}, q, a0);
    xfer(p, q, a1);
    xfer(v, q, a2);
    stop();
    nak = nak | a0 | a1 | a2;
  endtask : write_reg
  // single byte read, master answers with no-ack; a device pulling that slot low counts too
  task automatic read_reg(input logic [7:0] p, output logic [7:0] v);
    logic [7:0] q;
    logic a0;
    logic a1;
    logic a2;
    logic a3;
    start();
    xfer({SMB_DEV_ADDR, 1'b0}, q, a0);
    xfer(p, q, a1);
    start();
    xfer({SMB_DEV_ADDR, 1'b1}, q, a2);
    xfer(8'hFF, v, a3);
    stop();
    nak = nak | a0 | a1 | a2 | ~a3;
  endtask : read_reg
endmodule : vmac_smb_host

//--- tb/vmac_top_tb.sv
// self-checking bench for the voltage monitor converter control
// assumes the bus master model and a comparator fed from a per-channel code table
`timescale 1ns/1ps
module vmac_top_tb;
  import vmac_pkg::*;
  localparam int CONV = 40;
  localparam int ROUND = 4000;
  logic clk;
  logic sys_rst;
  logic scl;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic alert_n;
  logic [9:0] dac;
  logic [2:0] mux;
  logic bypass;
  logic scale5;
  logic a;
  logic [2:0] m0;
  logic [7:0] rd;
  logic [9:0] ana [8];
  logic [2:0] codes [5] = '{CH_CHIPSET, CH_DEVICE, CH_REMOTE1, CH_LOCAL, CH_REMOTE2};
  int num_errors;
  int checks_done;
  // codes end in binary 10 so a one-step comparator ambiguity leaves bits 9:2 alone
  vmac_top #(.CONV_CYCLES(CONV)) DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .smb_scl(scl),
    .smb_sda_in(sda),
    .smb_sda_out(sda_out),
    .smb_sda_oe(sda_oe),
    .smb_alert_n(alert_n),
    .adc_cmp(ana[mux] > dac),
    .adc_dac_code(dac),
    .adc_mux_sel(mux),
    .atten_bypass(bypass),
    .device_5v_scale(scale5)
  );
  vmac_smb_host host (.clk(clk), .sda_oe(sda_oe), .sda_out(sda_out), .scl(scl), .sda(sda));
  always #12.5 clk = ~clk;
  task automatic cy(input int n);
    repeat (n) @(posedge clk);
  endtask : cy
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rr(input logic [7:0] p, input logic [7:0] exp);
    logic [7:0] v;
    host.read_reg(p, v);
    check("register", v, exp);
  endtask : rr
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    host.write_reg(p, v);
  endtask : wr
  task automatic wrap_up;
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    num_errors = 0;
    checks_done = 0;
    for (int i = 0; i < 8; i++) ana[i] = 10'h102;
    ana[CH_CHIPSET] = NOMINAL_CODE + 10'h002;
    ana[CH_DEVICE] = 10'h2A6;
    cy(2);
    sys_rst <= 1'b0;
    cy(4);
    for (int i = 0; i < 4; i++) rr(8'(REG_CS_LOW + i), i[0] ? LIMIT_HI_RST : LIMIT_LO_RST);
    host.start();
    host.xfer(8'h60, rd, a);
    host.stop();
    check("foreign ack", 8'(a), 8'h01);
    cy(ROUND);
    rr(REG_CS_READING, ana[CH_CHIPSET][9:2]);
    rr(REG_DS_READING, ana[CH_DEVICE][9:2]);
    check("alert", 8'(alert_n), 8'h01);
    wr(REG_CS_READING, 8'h55);
    rr(REG_CS_READING, ana[CH_CHIPSET][9:2]);
    wr(8'h30, 8'h5A);
    rr(8'h30, 8'h00);
    wr(REG_CONFIG_TWO, 8'h20);
    check("bypass", 8'(bypass), 8'h01);
    wr(REG_CONFIG_ONE, 8'h80);
    check("scale", 8'(scale5), 8'h01);
    rr(REG_CONFIG_TWO, 8'h20);
    // status is sticky: the first read after a fix may still show the old flag
    wr(REG_CS_HIGH, 8'hBF);
    cy(ROUND);
    check("alert", 8'(alert_n), 8'h00);
    rr(REG_STATUS, 8'h01);
    wr(REG_CS_HIGH, 8'hFF);
    cy(ROUND);
    host.read_reg(REG_STATUS, rd);
    rr(REG_STATUS, 8'h00);
    check("alert", 8'(alert_n), 8'h01);
    wr(REG_DS_LOW, 8'hAA);
    cy(ROUND);
    check("alert", 8'(alert_n), 8'h00);
    rr(REG_STATUS, 8'h02);
    wr(REG_DS_LOW, 8'h00);
    wr(REG_CONFIG_TWO, 8'h10);
    cy(800);
    m0 = mux;
    cy(2 * CONV);
    check("mux step", 8'(mux != m0), 8'h01);
    wr(REG_CONFIG_TWO, 8'h50);
    for (int i = 0; i < 5; i++) begin
      wr(REG_FAN1_CHSEL, {codes[i], 5'h00});
      cy(3 * CONV);
      repeat (3) begin
        check("mux", 8'(mux), 8'(codes[i]));
        cy(CONV);
      end
    end
    // unused select code 011 falls back to the chipset supply
    wr(REG_FAN1_CHSEL, 8'h60);
    cy(3 * CONV);
    check("mux", 8'(mux), 8'(CH_CHIPSET));
    wr(REG_FAN1_CHSEL, {CH_DEVICE, 5'h00});
    ana[CH_DEVICE] <= 10'h1F2;
    cy(4 * CONV);
    rr(REG_DS_READING, ana[CH_DEVICE][9:2]);
    rr(REG_FAN1_CHSEL, 8'h40);
    check("ack", 8'(host.nak), 8'h00);
    wrap_up();
  end
endmodule : vmac_top_tb
